// ### pgm_consts.svh
`ifndef PGM_CONSTS_SVH
`define PGM_CONSTS_SVH

// Register byte offsets
`define PGM_OFF_CTRL1 12'h000
`define PGM_OFF_CTRL2 12'h004
`define PGM_OFF_EVENT 12'h008
`define PGM_OFF_MASK 12'h00c
`define PGM_OFF_STATUS 12'h010
`define PGM_OFF_FAULT 12'h014
`define PGM_OFF_RESET 12'h018

// Rail order in every 4-bit rail field: buck0, buck1, ldo0, ldo1
`define PGM_RAILS 4
`define PGM_LDO0 2

// CTRL1 fields
`define PGM_C1_SEL_LSB 0
`define PGM_C1_WIN_LSB 4
`define PGM_C1_POL 8
`define PGM_C1_OD 9
`define PGM_CTRL1_RST 32'h0000_010f

// CTRL2 fields
`define PGM_C2_MODE 0
`define PGM_C2_TWARN 1
`define PGM_C2_GATE 2
`define PGM_CTRL2_RST 32'h0000_0000

// EVENT and MASK bit positions
`define PGM_EV_LDO0 0
`define PGM_EV_LDO1 1
`define PGM_EV_FALL 2
`define PGM_EV_CLK 3
`define PGM_EV_MEAS 4
`define PGM_EV_RST 5
`define PGM_EV_OVP 6
`define PGM_EV_TSD 7
`define PGM_EV_W 8
`define PGM_MASK_RST 8'h00

// STATUS fields
`define PGM_ST_RAIL_LSB 0
`define PGM_ST_GOOD 4
`define PGM_ST_CLK 5
`define PGM_ST_TWARN 6
`define PGM_ST_OVP 7
`define PGM_ST_TSD 8

// RESET register
`define PGM_RS_SW 0

// Gated hold-off period
`define PGM_CLK_MHZ 50
`define PGM_HOLD_US 800
`define PGM_HOLD_CYCLES (`PGM_HOLD_US * `PGM_CLK_MHZ)

`endif

// ### pgm_monitor.sv
`include "pgm_consts.svh"
module pgm_monitor
  import pgm_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `PGM_HOLD_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [3:0] rail_enabled_in,
  input wire logic [3:0] rail_ramping_in,
  input wire logic [3:0] rail_above_uv_in,
  input wire logic [3:0] rail_below_ov_in,
  input wire logic thermal_warn_status_in,
  input wire logic input_overvoltage_in,
  input wire logic thermal_shutdown_in,
  input wire logic sync_clk_present_in,
  input wire logic clk_detect_enabled_in,
  input wire logic current_meas_done_in,
  input wire logic otp_load_done_in,
  input wire logic otp_mode_in,
  input wire logic otp_reset_mask_in,
  output logic sw_reset_out,
  output logic power_good_output_out,
  output logic power_good_output_oe_out,
  output logic interrupt_out_n
);

  logic [31:0] ctrl1_q, ctrl1_d;
  logic [31:0] ctrl2_q, ctrl2_d;
  logic [7:0] event_q, event_d;
  logic [7:0] mask_q, mask_d;
  logic [3:0] fault_q, fault_d;
  logic [31:0] prdata_q, prdata_d;
  logic swrst_q;
  logic good_q, good_d;
  pgm_state_t state_q, state_d;
  logic [15:0] hold_q, hold_d;
  logic [3:0] valid_q, en_q, ramp_q;
  logic clk_q, cdet_q;

  // APB decode
  wire setup = psel_in & ~penable_in;
  wire wr = psel_in & penable_in & pwrite_in;
  wire hit_c1 = paddr_in == `PGM_OFF_CTRL1;
  wire hit_c2 = paddr_in == `PGM_OFF_CTRL2;
  wire hit_ev = paddr_in == `PGM_OFF_EVENT;
  wire hit_mk = paddr_in == `PGM_OFF_MASK;
  wire hit_st = paddr_in == `PGM_OFF_STATUS;
  wire hit_ft = paddr_in == `PGM_OFF_FAULT;
  wire hit_rs = paddr_in == `PGM_OFF_RESET;
  wire mapped = hit_c1 | hit_c2 | hit_ev | hit_mk | hit_st | hit_ft | hit_rs;
  wire [7:0] ev_w1c = (wr & hit_ev) ? pwdata_in[7:0] : 8'h00;
  wire [3:0] ft_w1c = (wr & hit_ft) ? pwdata_in[3:0] : 4'h0;

  // Configuration fields
  wire [3:0] sel = ctrl1_q[`PGM_C1_SEL_LSB +: `PGM_RAILS];
  wire [3:0] win = ctrl1_q[`PGM_C1_WIN_LSB +: `PGM_RAILS];
  wire pol = ctrl1_q[`PGM_C1_POL];
  wire od = ctrl1_q[`PGM_C1_OD];
  wire continuous = ctrl2_q[`PGM_C2_MODE];
  wire twarn_sel = ctrl2_q[`PGM_C2_TWARN];
  wire fault_gate = ctrl2_q[`PGM_C2_GATE];

  // Rail checks
  wire [3:0] rail_valid = rail_above_uv_in & (~win | rail_below_ov_in);
  wire [3:0] watched = sel & rail_enabled_in;
  wire [3:0] rail_bad = watched & ~rail_valid;
  wire other_bad = (twarn_sel & thermal_warn_status_in) | event_q[`PGM_EV_OVP] | event_q[`PGM_EV_TSD];
  wire all_ok = ~|rail_bad & ~other_bad;
  wire any_ramp = |(rail_ramping_in & rail_enabled_in);
  wire enable_rise = |(rail_enabled_in & ~en_q);
  wire ramp_start = |(rail_ramping_in & ~ramp_q);
  wire hold_done = hold_q == 16'h0000;

  // Event sources
  wire [1:0] ldo_fall = valid_q[`PGM_LDO0 +: 2] & ~rail_valid[`PGM_LDO0 +: 2];
  wire clk_change = clk_detect_enabled_in & cdet_q & (clk_q != sync_clk_present_in);
  wire clk_missing = clk_detect_enabled_in & ~cdet_q & ~sync_clk_present_in;
  wire loaded_now = (state_q == PGM_ST_UNLOADED) & otp_load_done_in;
  logic [7:0] ev_set;

  always_comb begin
    ev_set = 8'h00;
    ev_set[`PGM_EV_LDO0] = ldo_fall[0] & ~mask_q[`PGM_EV_LDO0];
    ev_set[`PGM_EV_LDO1] = ldo_fall[1] & ~mask_q[`PGM_EV_LDO1];
    ev_set[`PGM_EV_FALL] = good_q & ~good_d & ~mask_q[`PGM_EV_FALL];
    ev_set[`PGM_EV_CLK] = (clk_change | clk_missing) & ~mask_q[`PGM_EV_CLK];
    ev_set[`PGM_EV_MEAS] = current_meas_done_in & ~mask_q[`PGM_EV_MEAS];
    ev_set[`PGM_EV_RST] = loaded_now & ~otp_reset_mask_in;
    // Stays set while the condition persists, so a clear cannot succeed early
    ev_set[`PGM_EV_OVP] = input_overvoltage_in;
    ev_set[`PGM_EV_TSD] = thermal_shutdown_in;
  end

  // Set wins over a same-cycle write-one clear
  assign event_d = (event_q & ~ev_w1c) | ev_set;

  // Power-good sequencing
  always_comb begin
    state_d = state_q;
    good_d = good_q;
    hold_d = hold_q;
    fault_d = fault_q & ~ft_w1c;
    case (state_q)
      PGM_ST_UNLOADED: begin
        good_d = 1'b0;
        if (otp_load_done_in) begin
          good_d = 1'b1;
          state_d = PGM_ST_RUN;
        end
      end
      PGM_ST_HOLD: begin
        // Output frozen during the hold-off
        if (hold_done) begin
          state_d = PGM_ST_RUN;
        end else begin
          hold_d = hold_q - 16'h0001;
        end
      end
      PGM_ST_RUN: begin
        if (!continuous) begin
          if (enable_rise | ramp_start) begin
            state_d = PGM_ST_HOLD;
            hold_d = 16'(HOLD_CYCLES - 1);
          end else begin
            fault_d = fault_d | rail_bad;
            good_d = all_ok & ~|fault_d;
          end
        end else begin
          if (!any_ramp) begin
            fault_d = fault_d | rail_bad;
          end
          good_d = all_ok & ~any_ramp & ~enable_rise
            & ~(fault_gate & |fault_d);
        end
      end
      default: begin
        state_d = PGM_ST_UNLOADED;
        good_d = 1'b0;
      end
    endcase
  end

  // Register writes
  always_comb begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    mask_d = mask_q;
    if (wr & hit_c1) begin
      ctrl1_d = {22'h0, pwdata_in[9:0]};
    end
    if (wr & hit_c2) begin
      ctrl2_d = {29'h0, pwdata_in[2:0]};
    end
    if (loaded_now) begin
      ctrl2_d[`PGM_C2_MODE] = otp_mode_in;
    end
    if (wr & hit_mk) begin
      mask_d = pwdata_in[7:0];
    end
  end

  wire [31:0] status_w = {23'h0, event_q[`PGM_EV_TSD], event_q[`PGM_EV_OVP], thermal_warn_status_in,
    sync_clk_present_in, good_q, rail_valid};

  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (hit_c1) prdata_d = ctrl1_q;
      if (hit_c2) prdata_d = ctrl2_q;
      if (hit_ev) prdata_d = {24'h0, event_q};
      if (hit_mk) prdata_d = {24'h0, mask_q};
      if (hit_st) prdata_d = status_w;
      if (hit_ft) prdata_d = {28'h0, fault_q};
    end
  end

  // Software reset returns control, mask, event, fault and sequencing state to defaults one cycle after the write
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      swrst_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      swrst_q <= wr & hit_rs & pwdata_in[`PGM_RS_SW];
      prdata_q <= prdata_d;
    end
  end

  // Undervoltage reset is the async reset: defaults and no flag raised
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl1_q <= `PGM_CTRL1_RST;
      ctrl2_q <= `PGM_CTRL2_RST;
      mask_q <= `PGM_MASK_RST;
      event_q <= 8'h00;
      fault_q <= 4'h0;
      good_q <= 1'b0;
      state_q <= PGM_ST_UNLOADED;
      hold_q <= 16'h0000;
    end else if (swrst_q) begin
      ctrl1_q <= `PGM_CTRL1_RST;
      ctrl2_q <= `PGM_CTRL2_RST;
      mask_q <= `PGM_MASK_RST;
      event_q <= 8'h00;
      fault_q <= 4'h0;
      good_q <= 1'b0;
      state_q <= PGM_ST_UNLOADED;
      hold_q <= 16'h0000;
    end else begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      mask_q <= mask_d;
      event_q <= event_d;
      fault_q <= fault_d;
      good_q <= good_d;
      state_q <= state_d;
      hold_q <= hold_d;
    end
  end

  // Edge history for event detection
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      valid_q <= 4'h0;
      en_q <= 4'h0;
      ramp_q <= 4'h0;
      clk_q <= 1'b0;
      cdet_q <= 1'b0;
    end else begin
      valid_q <= rail_valid;
      en_q <= rail_enabled_in;
      ramp_q <= rail_ramping_in;
      clk_q <= sync_clk_present_in;
      cdet_q <= clk_detect_enabled_in;
    end
  end

  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign prdata_out = prdata_q;
  assign sw_reset_out = swrst_q;

  // Pin level: polarity applies here only, never to status or events
  wire pin_level = pol ? good_q : ~good_q;
  assign power_good_output_out = od ? 1'b0 : pin_level;
  assign power_good_output_oe_out = od ? ~pin_level : 1'b1;
  assign interrupt_out_n = ~|event_q;

endmodule

// ### pgm_monitor_assertions.sv
module pgm_monitor_assertions #(
  parameter int unsigned HOLD_CYCLES = 20
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic input_overvoltage_in,
  input wire logic thermal_shutdown_in,
  input wire logic sw_reset_out,
  input wire logic interrupt_out_n
);
  wire logic acc = psel_in && penable_in;
  wire logic ev_clear = acc && pwrite_in && paddr_in == 12'h008;
  wire logic rst_wr = acc && pwrite_in && paddr_in == 12'h018 && pwdata_in[0];
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  ready_const_a: assert property (pready_out)
    else $error("pready low");
  err_access_a: assert property (pslverr_out |-> acc)
    else $error("pslverr outside access phase");
  unmapped_zero_a: assert property (acc && !pwrite_in && pslverr_out |-> prdata_out == 32'h0)
    else $error("refused read returned data");
  ovp_irq_a: assert property (input_overvoltage_in |=> !interrupt_out_n)
    else $error("overvoltage did not pull interrupt low");
  tsd_irq_a: assert property (thermal_shutdown_in |=> !interrupt_out_n)
    else $error("shutdown did not pull interrupt low");
  swr_pulse_a: assert property (sw_reset_out |=> !sw_reset_out)
    else $error("software reset pulse too long");
  swr_cause_a: assert property ($rose(sw_reset_out) |-> $past(rst_wr) || $past(rst_wr, 2))
    else $error("software reset without request");
  irq_release_a: assert property ($rose(interrupt_out_n) |-> $past(ev_clear) || $past(sw_reset_out))
    else $error("interrupt released without clear");
endmodule

bind pgm_monitor pgm_monitor_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (.*);

// ### pgm_pkg.sv
package pgm_pkg;
  typedef enum logic [1:0] {
    PGM_ST_UNLOADED = 2'b00,
    PGM_ST_HOLD = 2'b01,
    PGM_ST_RUN = 2'b10
  } pgm_state_t;
endpackage

// ### pgm_por_model.sv
module pgm_por_model (
  input wire logic clock_in,
  input wire logic pin_data_in,
  input wire logic pin_oe_in,
  input wire logic active_high_in,
  output logic pin_level_out,
  output logic cpu_run_out
);
  // Board pull-up: a released open-drain pin reads high
  assign pin_level_out = pin_oe_in ? pin_data_in : 1'b1;
  always_ff @(posedge clock_in) begin
    cpu_run_out <= pin_level_out == active_high_in;
  end
endmodule

// ### power_good_monitor_irq_tb.sv
module power_good_monitor_irq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, pol_hi = 1;
  logic [11:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out;
  logic pready_out, pslverr_out, sw_reset_out, power_good_output_out, power_good_output_oe_out;
  logic interrupt_out_n, level, run;
  logic [3:0] rail_enabled_in = '0, rail_ramping_in = '0, rail_above_uv_in = 4'hf, rail_below_ov_in = 4'hf;
  logic thermal_warn_status_in = 0, input_overvoltage_in = 0, thermal_shutdown_in = 0;
  logic sync_clk_present_in = 0, clk_detect_enabled_in = 0, current_meas_done_in = 0;
  logic otp_load_done_in = 0, otp_mode_in = 0, otp_reset_mask_in = 0;
  int n_errors = 0, compares = 0;
  pgm_monitor #(.HOLD_CYCLES(20)) i_dut (.*);
  pgm_por_model i_cpu (.clock_in(clock_in), .pin_data_in(power_good_output_out),
    .pin_oe_in(power_good_output_oe_out), .active_high_in(pol_hi), .pin_level_out(level), .cpu_run_out(run));
  always #10 clock_in = ~clock_in;
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Idle the bus while waiting so no transfer repeats
  task automatic st(input int n);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    repeat (n) @(posedge clock_in);
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (pready_out !== 1'b1 && k < 50);
    r = prdata_out;
    // Release after the answer edge and let one edge pass so the result has settled
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clock_in);
    if (k == 50) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), r & m, e);
  endtask
  initial begin
    st(6);
    reset_n_in <= 1'b1;
    st(1);
    rd(12'h000, 32'hffffffff, 32'h10f);
    rd(12'h01c, 32'hffffffff, 32'h0);
    otp_load_done_in <= 1'b1;
    st(1);
    otp_load_done_in <= 1'b0;
    st(3);
    rd(12'h008, 32'hff, 32'h20);
    chk("irq", interrupt_out_n, 1'b0);
    chk("run", run, 1'b1);
    rd(12'h010, 32'h10, 32'h10);
    wr(12'h008, 32'h20);
    chk("irq", interrupt_out_n, 1'b1);
    rail_enabled_in <= 4'h4;
    rail_above_uv_in <= 4'hb;
    st(10);
    chk("run", run, 1'b1);
    st(25);
    chk("run", run, 1'b0);
    rd(12'h014, 32'hf, 32'h4);
    rail_above_uv_in <= 4'hf;
    st(5);
    chk("run", run, 1'b0);
    wr(12'h014, 32'h4);
    rd(12'h014, 32'hf, 32'h0);
    st(4);
    chk("run", run, 1'b1);
    wr(12'h008, 32'hff);
    wr(12'h004, 32'h1);
    rail_below_ov_in <= 4'hb;
    st(4);
    chk("run", run, 1'b1);
    wr(12'h000, 32'h14f);
    st(4);
    chk("run", run, 1'b0);
    rd(12'h008, 32'h1, 32'h1);
    rail_below_ov_in <= 4'hf;
    st(4);
    chk("run", run, 1'b1);
    rd(12'h014, 32'hf, 32'h4);
    wr(12'h004, 32'h5);
    st(3);
    chk("run", run, 1'b0);
    wr(12'h014, 32'h4);
    st(3);
    chk("run", run, 1'b1);
    wr(12'h008, 32'hff);
    wr(12'h00c, 32'h1);
    rail_above_uv_in <= 4'hb;
    st(4);
    rd(12'h008, 32'h5, 32'h4);
    rail_above_uv_in <= 4'hf;
    wr(12'h014, 32'h4);
    rail_ramping_in <= 4'h4;
    st(3);
    chk("run", run, 1'b0);
    rail_ramping_in <= 4'h0;
    st(4);
    chk("run", run, 1'b1);
    wr(12'h000, 32'h10b);
    rail_above_uv_in <= 4'hb;
    st(4);
    chk("run", run, 1'b1);
    rail_enabled_in <= 4'h0;
    wr(12'h000, 32'h10f);
    st(4);
    chk("run", run, 1'b1);
    rail_above_uv_in <= 4'hf;
    pol_hi <= 1'b0;
    wr(12'h000, 32'h00f);
    st(3);
    chk("pin", power_good_output_out, 1'b0);
    rd(12'h010, 32'h10, 32'h10);
    wr(12'h000, 32'h20f);
    st(3);
    chk("level", level, 1'b0);
    pol_hi <= 1'b1;
    wr(12'h000, 32'h10f);
    for (int i = 0; i < 2; i++) begin
      wr(12'h008, 32'hff);
      {thermal_shutdown_in, input_overvoltage_in} <= 2'h1 << i;
      st(3);
      chk("irq", interrupt_out_n, 1'b0);
      {thermal_shutdown_in, input_overvoltage_in} <= 2'h0;
      st(3);
      chk("run", run, 1'b0);
      rd(12'h010, 32'h180, 32'h80 << i);
      wr(12'h008, 32'hff);
      st(3);
      chk("run", run, 1'b1);
    end
    current_meas_done_in <= 1'b1;
    clk_detect_enabled_in <= 1'b1;
    st(1);
    current_meas_done_in <= 1'b0;
    st(3);
    rd(12'h008, 32'h18, 32'h18);
    wr(12'h008, 32'h18);
    sync_clk_present_in <= 1'b1;
    st(3);
    rd(12'h008, 32'h18, 32'h8);
    rd(12'h010, 32'h20, 32'h20);
    wr(12'h018, 32'h1);
    st(4);
    rd(12'h004, 32'hff, 32'h0);
    chk("run", run, 1'b0);
    otp_load_done_in <= 1'b1;
    st(1);
    otp_load_done_in <= 1'b0;
    st(3);
    rd(12'h008, 32'h20, 32'h20);
    reset_n_in <= 1'b0;
    st(2);
    reset_n_in <= 1'b1;
    st(2);
    rd(12'h008, 32'hff, 32'h0);
    chk("irq", interrupt_out_n, 1'b1);
    end_sim();
  end
endmodule
